// ---- dv/dof_alu_chk.sv ----
`timescale 1ns/100ps

`include "dof_cfg.svh"

// ==========================================================
// port checker for the double-operand datapath
module dof_alu_chk
    import dof_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // writeback
    input wire logic [15:0] dst_data,
    input wire logic dst_we
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    logic instr_ack;
    logic unmapped;
    logic [15:0] src_r;
    assign instr_ack = avs_write && !avs_waitrequest && avs_address == `DOF_OFS_INSTR
        && avs_byteenable[1:0] == 2'h3;
    assign unmapped = avs_address[1:0] != 2'h0 || avs_address > `DOF_OFS_GPR_LAST
        || (avs_address > `DOF_OFS_DECODE && avs_address < `DOF_OFS_GPR_BASE);

    // shadow of the source operand, so a copy can be tied to its cause
    always_ff @(posedge core_clk)
    begin
        if (rst)
            src_r <= 16'h0000;
        else if (avs_write && !avs_waitrequest && avs_address == `DOF_OFS_SRC
            && avs_byteenable[1:0] == 2'h3)
            src_r <= avs_writedata[15:0];
    end

    a_ack_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_ack_after_req: assert property ((avs_read || avs_write) && avs_waitrequest
        && $past(avs_waitrequest) |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");
    a_ack_needs_req: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("answer without a request");
    a_no_stray_wb: assert property (dst_we |-> $past(instr_ack))
        else $error("writeback without an executed instruction");
    a_wb_one_pulse: assert property (dst_we |=> !dst_we)
        else $error("writeback strobe longer than one cycle");
    a_wb_data_holds: assert property (!dst_we |-> $stable(dst_data))
        else $error("writeback data moved without strobe");
    a_cmp_no_wb: assert property (instr_ack && avs_writedata[14:12] inside {3'h2, 3'h3}
        |=> !dst_we)
        else $error("compare or test wrote back");
    a_store_wb: assert property (instr_ack && avs_writedata[14:12] inside
        {3'h1, 3'h4, 3'h5, 3'h6} |=> dst_we)
        else $error("storing operation gave no writeback");
    a_copy_value: assert property (instr_ack && avs_writedata[15:12] == 4'h1
        |=> dst_data == src_r)
        else $error("word copy wrote wrong value");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest && unmapped
        |-> avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_upper_zero: assert property (avs_read && !avs_waitrequest
        && avs_address != `DOF_OFS_DECODE |-> avs_readdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
endmodule

bind dof_alu dof_alu_chk u_chk (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .dst_data(dst_data), .dst_we(dst_we));

// ---- dv/tb_double_operand_alu_flags.sv ----
`timescale 1ns/100ps

`include "dof_cfg.svh"

// ==========================================================
// bench for the double-operand datapath
module tb_double_operand_alu_flags;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [15:0] dst_data;
    logic dst_we;
    logic [31:0] q;
    int error_cnt = 0;
    int cmp_count = 0;

    always #50 core_clk = ~core_clk;

    dof_alu dut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .dst_data(dst_data), .dst_we(dst_we));

    // ======================================================
    // verdict
    task results();
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // ======================================================
    // avalon master: hold until waitrequest is sampled low
    task acc(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {16'h0000, d};
        avs_byteenable <= be;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0 && n < 50)
        begin
            n++;
            @(posedge core_clk);
        end
        if (n == 50)
        begin
            error_cnt++;
            results();
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [15:0] d);
        acc(1'b1, a, d, 4'h3);
    endtask

    task rd(input logic [7:0] a);
        acc(1'b0, a, 16'h0000, 4'hF);
    endtask

    // load operands and flags, execute, then check writeback, flags and destination
    task op(input logic [15:0] ins, s, d, input logic [3:0] pi, input logic we,
        input logic [15:0] res, input logic [3:0] po);
        wr(`DOF_OFS_SRC, s);
        wr(`DOF_OFS_DST, d);
        wr(`DOF_OFS_PSW, {12'h000, pi});
        wr(`DOF_OFS_INSTR, ins);
        @(negedge core_clk);
        chk_bit(dst_we, we);
        if (we)
            chk_word({16'h0000, dst_data}, {16'h0000, res});
        rd(`DOF_OFS_PSW);
        chk_word(q, {28'h000_0000, po});
        rd(`DOF_OFS_DST);
        chk_word(q, {16'h0000, we ? res : d});
    endtask

    initial
    begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        rd(`DOF_OFS_PSW);
        chk_word(q, 32'h0000_0000);
        rd(`DOF_OFS_PC);
        chk_word(q, 32'h0000_0000);
        wr(8'h20, 16'hBEEF);
        rd(8'h20);
        chk_word(q, 32'h0000_0000);
        acc(1'b1, `DOF_OFS_INSTR, 16'h1042, 4'h1);
        @(negedge core_clk);
        chk_bit(dst_we, 1'b0);
        op(16'h1042, 16'h8000, 16'h1234, 4'h3, 1'b1, 16'h8000, 4'h9);
        op(16'h9042, 16'h1200, 16'hABCD, 4'h2, 1'b1, 16'hAB00, 4'h4);
        op(16'h2042, 16'h0001, 16'hFFFF, 4'h0, 1'b0, 16'h0000, 4'h3);
        op(16'h2042, 16'h5555, 16'h5555, 4'h9, 1'b0, 16'h0000, 4'h4);
        op(16'hA042, 16'hFF00, 16'h3301, 4'h0, 1'b0, 16'h0000, 4'h9);
        rd(`DOF_OFS_DECODE);
        chk_word(q, 32'h0001_1042);
        op(16'h3042, 16'hF0F0, 16'h0F0F, 4'h1, 1'b0, 16'h0000, 4'h5);
        op(16'hB042, 16'h8080, 16'h80FF, 4'h2, 1'b0, 16'h0000, 4'h8);
        op(16'h4042, 16'h00FF, 16'h8F0F, 4'h1, 1'b1, 16'h8F00, 4'h9);
        op(16'hC042, 16'h00FF, 16'h12AB, 4'h0, 1'b1, 16'h1200, 4'h4);
        op(16'h5042, 16'h0000, 16'h0000, 4'h1, 1'b1, 16'h0000, 4'h5);
        op(16'hD042, 16'h0080, 16'h3400, 4'h0, 1'b1, 16'h3480, 4'h8);
        op(16'h6042, 16'h7FFF, 16'h0001, 4'h0, 1'b1, 16'h8000, 4'hA);
        op(16'h6042, 16'hFFFF, 16'h0001, 4'h0, 1'b1, 16'h0000, 4'h5);
        op(16'h6042, 16'h8000, 16'h8000, 4'h0, 1'b1, 16'h0000, 4'h7);
        op(16'hE042, 16'h0001, 16'h8000, 4'h0, 1'b1, 16'h7FFF, 4'h2);
        op(16'hE042, 16'h0002, 16'h0001, 4'h0, 1'b1, 16'hFFFF, 4'h9);
        wr(8'h4C, 16'h0F0F);
        op(16'h78C2, 16'h0000, 16'hFFFF, 4'h3, 1'b1, 16'hF0F0, 4'h9);
        rd(`DOF_OFS_RESULT);
        chk_word(q, 32'h0000_F0F0);
        wr(`DOF_OFS_INSTR, 16'h15EB);
        rd(`DOF_OFS_DECODE);
        chk_word(q, 32'h0002_15EB);
        wr(`DOF_OFS_INSTR, 16'h0A2B);
        rd(`DOF_OFS_DECODE);
        chk_word(q, 32'h0000_202B);
        wr(`DOF_OFS_PC, 16'h1000);
        wr(`DOF_OFS_INSTR, 16'h01FE);
        rd(`DOF_OFS_PC);
        chk_word(q, 32'h0000_0FFC);
        wr(`DOF_OFS_PSW, 16'h0000);
        wr(`DOF_OFS_INSTR, 16'h0305);
        rd(`DOF_OFS_PC);
        chk_word(q, 32'h0000_0FFC);
        wr(`DOF_OFS_PSW, 16'h0004);
        wr(`DOF_OFS_INSTR, 16'h0302);
        rd(`DOF_OFS_PC);
        chk_word(q, 32'h0000_1000);
        // branch on plus: condition code 8 needs bit 15 of the word
        wr(`DOF_OFS_PSW, 16'h0001);
        wr(`DOF_OFS_INSTR, 16'h8002);
        rd(`DOF_OFS_PC);
        chk_word(q, 32'h0000_1004);
        rd(`DOF_OFS_DECODE);
        chk_word(q, 32'h0004_4000);
        wr(`DOF_OFS_PSW, 16'h0008);
        wr(`DOF_OFS_INSTR, 16'h8002);
        rd(`DOF_OFS_PC);
        chk_word(q, 32'h0000_1004);
        wr(`DOF_OFS_PSW, 16'h0008);
        wr(`DOF_OFS_INSTR, 16'h00B5);
        rd(`DOF_OFS_PSW);
        chk_word(q, 32'h0000_000D);
        wr(`DOF_OFS_INSTR, 16'h00A9);
        rd(`DOF_OFS_PSW);
        chk_word(q, 32'h0000_0004);
        // a code outside every decoded group only raises the unknown mark
        wr(`DOF_OFS_INSTR, 16'h7E00);
        rd(`DOF_OFS_DECODE);
        chk_word(q, 32'h0008_0000);
        results();
    end

    // watchdog: the whole sequence needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge core_clk);
        error_cnt++;
        results();
    end
endmodule

// ---- hdl/dof_alu.sv ----
`timescale 1ns/100ps

`include "dof_cfg.svh"

// Operation
// - word copy: N bit15, Z zero, V cleared
// - byte copy: N bit7, Z zero, V cleared
// - word compare: src minus dst, flags only
// - compare V: signs differ, result matches source
// - word compare carry from difference bit 16
// - byte compare: 9-bit difference, N7, C8
// - word test: AND, no store, N Z, V0
// - word clear: dst AND NOT src stored
// - word set: dst OR src stored
// - byte test/clear/set use bits 7..0
// - add: 17-bit sum, carry bit 16
// - add V: same signs, result sign differs
// - subtract: dst minus src, carry bit 16
// - subtract V: signs differ, result unlike dst
// - double operand: two independent mode/register fields
// - single operand: destination field only
// - register group: register XOR into destination
// - taken branch: pc plus twice signed offset
// - condition operators set/clear selected flags
module dof_alu
    import dof_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // writeback toward the address-mode logic
    output logic [15:0] dst_data,
    output logic dst_we
);

    // ======================================================
    // state
    dof_state_s st_r;
    dof_state_s st_nxt;

    assign avs_readdata = st_r.rdata;
    assign avs_waitrequest = st_r.waitreq;
    assign dst_data = st_r.dst_data;
    assign dst_we = st_r.dst_we;

    // ======================================================
    // branch condition test against the status flags
    function automatic logic dof_cond(input logic [3:0] code, input dof_flags_s f);
        logic nv;
        nv = f.n ^ f.v;
        case (code)
            4'h1: dof_cond = 1'b1;
            4'h2: dof_cond = !f.z;
            4'h3: dof_cond = f.z;
            4'h4: dof_cond = !nv;
            4'h5: dof_cond = nv;
            4'h6: dof_cond = !(f.z | nv);
            4'h7: dof_cond = f.z | nv;
            4'h8: dof_cond = !f.n;
            4'h9: dof_cond = f.n;
            4'hA: dof_cond = !(f.c | f.z);
            4'hB: dof_cond = f.c | f.z;
            4'hC: dof_cond = !f.v;
            4'hD: dof_cond = f.v;
            4'hE: dof_cond = !f.c;
            4'hF: dof_cond = f.c;
            default: dof_cond = 1'b0;
        endcase
    endfunction

    // merge a 16-bit write under the two low byte lanes
    function automatic logic [15:0] dof_lane(input logic [15:0] old, input logic [31:0] wd,
        input logic [3:0] be);
        dof_lane = old;
        if (be[0])
        begin
            dof_lane[7:0] = wd[7:0];
        end
        if (be[1])
        begin
            dof_lane[15:8] = wd[15:8];
        end
    endfunction

    // ======================================================
    // next state
    always_comb
    begin
        logic [15:0] ins;
        logic [2:0] op;
        logic is_byte;
        logic [15:0] s;
        logic [15:0] d;
        logic [16:0] r17;
        logic [8:0] r9;
        logic [15:0] res;
        logic sgn;
        logic zero;
        logic [15:0] disp;
        logic req;
        logic exec;
        logic [2:0] gidx;

        st_nxt = st_r;
        ins = avs_writedata[15:0];
        op = ins[14:12];
        is_byte = 1'b0;
        s = st_r.src;
        d = st_r.dst;
        r17 = 17'h00000;
        r9 = 9'h000;
        res = 16'h0000;
        sgn = 1'b0;
        zero = 1'b0;
        disp = 16'h0000;
        req = avs_read | avs_write;
        exec = 1'b0;
        gidx = avs_address[4:2];
        st_nxt.dst_we = 1'b0;

        // ==================================================
        // bus: every access stalls one cycle, then completes
        case (st_r.bus)
            DOF_BUS_IDLE:
            begin
                if (req)
                begin
                    st_nxt.bus = DOF_BUS_ACK;
                    st_nxt.waitreq = 1'b0;
                    st_nxt.rdata = 32'h00000000;
                    if (avs_read)
                    begin
                        case (avs_address)
                            `DOF_OFS_INSTR: st_nxt.rdata = {16'h0000, st_r.instr};
                            `DOF_OFS_SRC: st_nxt.rdata = {16'h0000, st_r.src};
                            `DOF_OFS_DST: st_nxt.rdata = {16'h0000, st_r.dst};
                            `DOF_OFS_RESULT: st_nxt.rdata = {16'h0000, st_r.result};
                            `DOF_OFS_PSW: st_nxt.rdata = {28'h0000000, st_r.psw};
                            `DOF_OFS_PC: st_nxt.rdata = {16'h0000, st_r.pc};
                            `DOF_OFS_DECODE:
                            begin
                                st_nxt.rdata = {12'h000, st_r.unknown, st_r.taken, st_r.wb,
                                    st_r.byte_op, 1'b0, st_r.group, st_r.fields};
                            end
                            default:
                            begin
                                if (avs_address >= `DOF_OFS_GPR_BASE &&
                                    avs_address <= `DOF_OFS_GPR_LAST &&
                                    avs_address[1:0] == 2'h0)
                                begin
                                    st_nxt.rdata = {16'h0000, st_r.gpr[gidx]};
                                end
                            end
                        endcase
                    end
                end
            end
            DOF_BUS_ACK:
            begin
                // a write takes effect at this edge; read data was latched on entry to ACK
                st_nxt.bus = DOF_BUS_IDLE;
                st_nxt.waitreq = 1'b1;
                if (avs_write)
                begin
                    case (avs_address)
                        `DOF_OFS_INSTR: exec = avs_byteenable[1:0] == 2'h3;
                        `DOF_OFS_SRC:
                            st_nxt.src = dof_lane(st_r.src, avs_writedata, avs_byteenable);
                        `DOF_OFS_DST:
                            st_nxt.dst = dof_lane(st_r.dst, avs_writedata, avs_byteenable);
                        `DOF_OFS_PSW:
                        begin
                            if (avs_byteenable[0])
                            begin
                                st_nxt.psw = avs_writedata[3:0];
                            end
                        end
                        `DOF_OFS_PC:
                            st_nxt.pc = dof_lane(st_r.pc, avs_writedata, avs_byteenable);
                        default:
                        begin
                            if (avs_address >= `DOF_OFS_GPR_BASE &&
                                avs_address <= `DOF_OFS_GPR_LAST &&
                                avs_address[1:0] == 2'h0)
                            begin
                                st_nxt.gpr[gidx] = dof_lane(st_r.gpr[gidx], avs_writedata,
                                    avs_byteenable);
                            end
                        end
                    endcase
                end
            end
            default:
            begin
                st_nxt.bus = DOF_BUS_IDLE;
                st_nxt.waitreq = 1'b1;
            end
        endcase

        // ==================================================
        // execute the instruction word written to INSTR
        if (exec)
        begin
            st_nxt.instr = ins;
            st_nxt.wb = 1'b0;
            st_nxt.taken = 1'b0;
            st_nxt.unknown = 1'b0;
            st_nxt.byte_op = 1'b0;
            st_nxt.fields = '0;
            st_nxt.group = DOF_GRP_OTHER;
            if (op != 3'h0 && op != 3'h7)
            begin
                // two independent mode/register fields
                st_nxt.group = DOF_GRP_DOUBLE;
                st_nxt.fields = {ins[11:9], ins[8:6], ins[5:3], ins[2:0]};
                // subtract owns the byte-marked add code
                is_byte = ins[`DOF_BIT_BYTE] && op != `DOF_OP_ADDSUB;
                st_nxt.byte_op = is_byte;
                case (op)
                    `DOF_OP_COPY:
                    begin
                        r17 = {1'b0, s};
                        r9 = {1'b0, s[7:0]};
                        st_nxt.wb = 1'b1;
                    end
                    `DOF_OP_COMPARE:
                    begin
                        r17 = {1'b0, s} - {1'b0, d};
                        r9 = {1'b0, s[7:0]} - {1'b0, d[7:0]};
                    end
                    `DOF_OP_TEST:
                    begin
                        r17 = {1'b0, d & s};
                        r9 = {1'b0, d[7:0] & s[7:0]};
                    end
                    `DOF_OP_CLEAR:
                    begin
                        r17 = {1'b0, d & ~s};
                        r9 = {1'b0, d[7:0] & ~s[7:0]};
                        st_nxt.wb = 1'b1;
                    end
                    `DOF_OP_SET:
                    begin
                        r17 = {1'b0, d | s};
                        r9 = {1'b0, d[7:0] | s[7:0]};
                        st_nxt.wb = 1'b1;
                    end
                    default:
                    begin
                        if (ins[`DOF_BIT_BYTE])
                        begin
                            r17 = {1'b0, d} - {1'b0, s};
                        end
                        else
                        begin
                            r17 = {1'b0, s} + {1'b0, d};
                        end
                        st_nxt.wb = 1'b1;
                    end
                endcase
                // a byte result replaces only the low byte of the destination
                res = is_byte ? {d[15:8], r9[7:0]} : r17[15:0];
                sgn = is_byte ? r9[7] : r17[15];
                zero = is_byte ? (r9[7:0] == 8'h00) : (r17[15:0] == 16'h0000);
                st_nxt.result = res;
                st_nxt.psw.n = sgn;
                st_nxt.psw.z = zero;
                st_nxt.psw.v = 1'b0;
                case (op)
                    `DOF_OP_COMPARE:
                    begin
                        if (is_byte)
                        begin
                            st_nxt.psw.v = (s[7] ^ d[7]) & ~(s[7] ^ r9[7]);
                            st_nxt.psw.c = r9[8];
                        end
                        else
                        begin
                            st_nxt.psw.v = (s[15] ^ d[15]) & ~(s[15] ^ r17[15]);
                            st_nxt.psw.c = r17[16];
                        end
                    end
                    `DOF_OP_ADDSUB:
                    begin
                        if (ins[`DOF_BIT_BYTE])
                        begin
                            st_nxt.psw.v = (d[15] ^ s[15]) & (d[15] ^ r17[15]);
                        end
                        else
                        begin
                            st_nxt.psw.v = ~(s[15] ^ d[15]) & (s[15] ^ r17[15]);
                        end
                        st_nxt.psw.c = r17[16];
                    end
                    default:
                    begin
                        st_nxt.psw.c = st_r.psw.c;
                    end
                endcase
                if (st_nxt.wb)
                begin
                    st_nxt.dst_we = 1'b1;
                    st_nxt.dst_data = res;
                    st_nxt.dst = res;
                end
            end
            else if (ins[15:9] == `DOF_XOR_PREFIX)
            begin
                // the register is XORed into the addressed operand, which takes the result
                st_nxt.group = DOF_GRP_REGXOR;
                st_nxt.fields = {3'h0, ins[8:6], ins[5:3], ins[2:0]};
                res = st_r.gpr[ins[8:6]] ^ d;
                st_nxt.result = res;
                st_nxt.psw.n = res[15];
                st_nxt.psw.z = res == 16'h0000;
                st_nxt.psw.v = 1'b0;
                st_nxt.wb = 1'b1;
                st_nxt.dst_we = 1'b1;
                st_nxt.dst_data = res;
                st_nxt.dst = res;
            end
            else if (ins[14:11] == 4'h1)
            begin
                // only a destination field exists here; flags are left alone
                st_nxt.group = DOF_GRP_SINGLE;
                st_nxt.byte_op = ins[`DOF_BIT_BYTE];
                st_nxt.fields = {6'h00, ins[5:3], ins[2:0]};
            end
            else if (ins[14:11] == 4'h0 && {ins[15], ins[10:8]} != 4'h0)
            begin
                // condition code 0 stays free for the operate and condition groups
                st_nxt.group = DOF_GRP_BRANCH;
                disp = {{7{ins[7]}}, ins[7:0], 1'b0};
                if (dof_cond({ins[15], ins[10:8]}, st_r.psw))
                begin
                    st_nxt.taken = 1'b1;
                    st_nxt.pc = st_r.pc + disp;
                end
            end
            else if (ins[15:5] == `DOF_CC_PREFIX)
            begin
                st_nxt.group = DOF_GRP_CCOP;
                if (ins[4])
                begin
                    st_nxt.psw = st_r.psw | ins[3:0];
                end
                else
                begin
                    st_nxt.psw = st_r.psw & ~ins[3:0];
                end
            end
            else
            begin
                // left to the miscellaneous and trap logic elsewhere
                st_nxt.unknown = 1'b1;
            end
        end
    end

    // ======================================================
    // register the state
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            st_r <= '0;
            st_r.bus <= DOF_BUS_IDLE;
            st_r.waitreq <= 1'b1;
            st_r.psw <= `DOF_RST_PSW;
            st_r.pc <= `DOF_RST_WORD;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

endmodule

// ---- hdl/dof_cfg.svh ----
`ifndef DOF_CFG_SVH
`define DOF_CFG_SVH

// ==========================================================
// register byte offsets on the avalon slave
`define DOF_OFS_INSTR 8'h00
`define DOF_OFS_SRC 8'h04
`define DOF_OFS_DST 8'h08
`define DOF_OFS_RESULT 8'h0C
`define DOF_OFS_PSW 8'h10
`define DOF_OFS_PC 8'h14
`define DOF_OFS_DECODE 8'h18
`define DOF_OFS_GPR_BASE 8'h40
`define DOF_OFS_GPR_LAST 8'h5C

// ==========================================================
// field positions
`define DOF_BIT_BYTE 15
`define DOF_PSW_N 3
`define DOF_PSW_Z 2
`define DOF_PSW_V 1
`define DOF_PSW_C 0
`define DOF_DEC_GROUP_LSB 12
`define DOF_DEC_BYTE 16
`define DOF_DEC_WB 17
`define DOF_DEC_TAKEN 18
`define DOF_DEC_UNKNOWN 19

// ==========================================================
// opcode fields (instr[14:12] of a double-operand word), then the instr[15:9] XOR and instr[15:5] condition-operator prefixes
`define DOF_OP_COPY 3'h1
`define DOF_OP_COMPARE 3'h2
`define DOF_OP_TEST 3'h3
`define DOF_OP_CLEAR 3'h4
`define DOF_OP_SET 3'h5
`define DOF_OP_ADDSUB 3'h6
`define DOF_XOR_PREFIX 7'h3C
`define DOF_CC_PREFIX 11'h005

// ==========================================================
// reset values
`define DOF_RST_WORD 16'h0000
`define DOF_RST_PSW 4'h0

`endif

// ---- hdl/dof_pkg.sv ----
package dof_pkg;

    // ======================================================
    // bus handshake states, gray order idle -> ack
    typedef enum logic [1:0]
    {
        DOF_BUS_IDLE = 2'h0,
        DOF_BUS_ACK = 2'h1
    } dof_bus_e;

    // ======================================================
    // instruction groups
    typedef enum logic [2:0]
    {
        DOF_GRP_OTHER = 3'h0,
        DOF_GRP_DOUBLE = 3'h1,
        DOF_GRP_SINGLE = 3'h2,
        DOF_GRP_REGXOR = 3'h3,
        DOF_GRP_BRANCH = 3'h4,
        DOF_GRP_CCOP = 3'h5
    } dof_group_e;

    typedef struct packed
    {
        logic [2:0] src_mode;
        logic [2:0] src_reg;
        logic [2:0] dst_mode;
        logic [2:0] dst_reg;
    } dof_fields_s;

    typedef struct packed
    {
        logic n;
        logic z;
        logic v;
        logic c;
    } dof_flags_s;

    typedef struct packed
    {
        dof_bus_e bus;
        logic waitreq;
        logic [31:0] rdata;
        logic [15:0] instr;
        logic [15:0] src;
        logic [15:0] dst;
        logic [15:0] result;
        dof_flags_s psw;
        logic [15:0] pc;
        dof_fields_s fields;
        dof_group_e group;
        logic byte_op;
        logic wb;
        logic taken;
        logic unknown;
        logic dst_we;
        logic [15:0] dst_data;
        logic [7:0][15:0] gpr;
    } dof_state_s;

endpackage
